// *** pkg/tas_pkg.sv ***
// package: register map, field layout, encodings and timing for trigger/srq
package tas_pkg;
  // register word addresses (byte address = 4 * word index on avalon)
  localparam logic [5:0] REG_CMD = 6'h00;
  localparam logic [5:0] REG_TRIG_CFG = 6'h01;
  localparam logic [5:0] REG_TRIG_COUNT = 6'h02;
  localparam logic [5:0] REG_TIMER_MS = 6'h03;
  localparam logic [5:0] REG_ARM2_CFG = 6'h04;
  localparam logic [5:0] REG_RANGE_SEL = 6'h05;
  localparam logic [5:0] REG_RANGE_REQ = 6'h06;
  localparam logic [5:0] REG_RANGE_FS = 6'h07;
  localparam logic [5:0] REG_AUTORANGE = 6'h08;
  localparam logic [5:0] REG_MEAS_EVENT = 6'h09;
  localparam logic [5:0] REG_MEAS_ENABLE = 6'h0A;
  localparam logic [5:0] REG_SRQ_ENABLE = 6'h0B;
  localparam logic [5:0] REG_STATUS_BYTE = 6'h0C;
  localparam logic [5:0] REG_BUF_CFG = 6'h0D;
  localparam logic [5:0] REG_TRIG_STATE = 6'h0E;
  localparam logic [5:0] REG_READ_CNT = 6'h0F;

  // command register bits (write one to act)
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RESET = 2;
  localparam int CMD_CLS = 3;
  localparam int CMD_PRESET = 4;

  // measurement event bits
  localparam int MEV_RDG_AVAIL = 5;
  localparam int MEV_BUF_FULL = 9;
  // status byte bits
  localparam int STB_MSB = 0;
  localparam int STB_RQS = 6;

  // trigger layer sources
  localparam logic [1:0] SRC_IMM = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_TIM = 2'h2;
  localparam logic [1:0] SRC_HOLD = 2'h3;

  // buffer feed control
  localparam logic [1:0] FEED_NEVER = 2'h0;
  localparam logic [1:0] FEED_NEXT = 2'h1;
  localparam logic [1:0] FEED_ALWAYS = 2'h2;

  localparam int NUM_FUNC = 4;
  localparam int NUM_RANGES = 5;
  localparam int BUF_PTS_W = 16;
  // full-scale range values in integer units
  localparam logic [31:0] RANGE_FS_0 = 32'h0000_0002;
  localparam logic [31:0] RANGE_FS_1 = 32'h0000_0014;
  localparam logic [31:0] RANGE_FS_2 = 32'h0000_00C8;
  localparam logic [31:0] RANGE_FS_3 = 32'h0000_03E8;
  localparam logic [31:0] RANGE_FS_4 = 32'h0000_2710;

  // timer: interval programmed in ms, 0.001 s minimum
  localparam int CLK_HZ = 125000000;
  localparam int TIMER_TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TIMER_TICK_MS;
  localparam logic [31:0] TIMER_MIN_MS = 32'h0000_0001;
  localparam logic [39:0] TIMER_MAX_MS = 40'h17_4876_E7FF;
  localparam logic [31:0] TIMER_RST_MS = 32'h0000_0001;
  localparam logic [15:0] STATUS_EN_RST = 16'h0000;
  localparam logic [7:0] SRQ_EN_RST = 8'h00;
  localparam logic [15:0] BUF_PTS_RST = 16'h0064;

  // trigger model states, gray along idle->arm2->trigger->measure
  typedef enum logic [1:0] {
    TAS_IDLE = 2'b00,
    TAS_ARM2 = 2'b01,
    TAS_TRIG = 2'b11,
    TAS_MEAS = 2'b10
  } tas_state_t;

  // trigger configuration carried as one word
  typedef struct packed {
    logic [1:0] source;
    logic infinite;
  } tas_trig_cfg_t;

  // measurement request and completion pair
  typedef struct packed {
    logic start;
    logic done;
  } tas_meas_hs_t;
endpackage

// *** rtl/tas_sync.sv ***
// two-stage synchroniser with edge pulse taken from the second and third stages
`timescale 1ns/10ps
module tas_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic rise
);
  logic s1_q, s2_q, s3_q;
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;
endmodule // tas_sync

// *** rtl/tas_top.sv ***
// trigger model, range bookkeeping and service request logic
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - range and autorange are held per measurement function
// - range argument is the largest value expected to be measured
// - requested range value is rounded to an integer before selection
// - range query returns full-scale of the range in use
// - source selection, two arm levels and a hold source exist
// - writing trigger settings never arms; only initiate leaves idle
// - reset command restores trigger controls and idles the model
// - trigger source after reset is immediate
// - external source takes one reading per external pulse
// - infinite count never leaves the trigger layer by itself
// - abort idles the model and ignores triggers until initiate
// - external arm layer two waits for first external pulse
// - immediate source starts readings back to back
// - timer source reads on entry then once per interval
// - service request raised on enabled status transitions
// - enable 512 plus srq enable 1 makes buffer full request
// - serial poll releases the service request line
// - an event register requests once until read or cleared
// - status setup survives reset command; only preset restores it
// - reading an event register returns then clears it; bit 9 full
// - feed next stores readings at once, stops when buffer full
// - timer interval spans 0.001 to 99999999.999 seconds; the 32-bit register holds up to 4294967.295 s, no upper clamp
module tas_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_trig_in,
  input wire logic serial_poll,
  input wire logic meas_done,
  output logic meas_start,
  output logic srq_out,
  output logic [7:0] poll_status
);
  logic ext_rise;
  logic tick;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  tas_pkg::tas_state_t st_q, st_d;
  tas_pkg::tas_trig_cfg_t tcfg_q, tcfg_d;
  logic arm2_ext_q, arm2_ext_d;
  logic [31:0] tcount_q, tcount_d;
  logic [31:0] done_cnt_q, done_cnt_d;
  logic [31:0] timer_ms_q, timer_ms_d;
  logic [31:0] ms_cnt_q, ms_cnt_d;
  logic tmr_fire_q, tmr_fire_d;
  logic [1:0] fsel_q, fsel_d;
  logic [2:0] rng_q [tas_pkg::NUM_FUNC];
  logic [2:0] rng_d [tas_pkg::NUM_FUNC];
  logic [tas_pkg::NUM_FUNC-1:0] auto_q, auto_d;
  logic [15:0] mev_q, mev_d;
  logic [15:0] men_q, men_d;
  logic [7:0] sre_q, sre_d;
  logic msb_prev_q, msb_prev_d;
  logic srq_q, srq_d;
  logic fired_q, fired_d;
  logic [1:0] feed_q, feed_d;
  logic [15:0] pts_q, pts_d;
  logic [15:0] stored_q, stored_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic wr, rd;
  logic [31:0] round_val;
  logic [2:0] pick;
  logic msb_now;
  logic [31:0] fs_sel;

  // external trigger pin crosses into clk domain
  tas_sync u_ext (
    .clk(clk),
    .rst(rst),
    .din(ext_trig_in),
    .rise(ext_rise)
  );

  // bus: one wait cycle; a write lands only at the edge with waitrequest
  // low, while a read snapshots its word at the first edge
  assign wr = avs_write & ack_q;
  assign rd = avs_read & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign ack_d = (avs_read | avs_write) & ~ack_q;

  // 1 ms tick from a free-running divider, one-cycle enable
  always_comb begin
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    tick = 1'b0;
    if (tick_cnt_q == 32'(tas_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      tick = 1'b1;
    end
  end

  // range pick: round half up, then smallest full-scale covering it
  always_comb begin
    round_val = 32'(avs_writedata[31:8]) + 32'(avs_writedata[7]);
    if (round_val <= tas_pkg::RANGE_FS_0) pick = 3'd0;
    else if (round_val <= tas_pkg::RANGE_FS_1) pick = 3'd1;
    else if (round_val <= tas_pkg::RANGE_FS_2) pick = 3'd2;
    else if (round_val <= tas_pkg::RANGE_FS_3) pick = 3'd3;
    else pick = 3'd4;
    case (rng_q[fsel_q])
      3'd0: fs_sel = tas_pkg::RANGE_FS_0;
      3'd1: fs_sel = tas_pkg::RANGE_FS_1;
      3'd2: fs_sel = tas_pkg::RANGE_FS_2;
      3'd3: fs_sel = tas_pkg::RANGE_FS_3;
      default: fs_sel = tas_pkg::RANGE_FS_4;
    endcase
  end

  // summary bit from enabled measurement events
  assign msb_now = |(mev_q & men_q);

  // trigger model and configuration next state
  always_comb begin
    st_d = st_q;
    tcfg_d = tcfg_q;
    arm2_ext_d = arm2_ext_q;
    tcount_d = tcount_q;
    done_cnt_d = done_cnt_q;
    timer_ms_d = timer_ms_q;
    ms_cnt_d = ms_cnt_q;
    tmr_fire_d = 1'b0;
    meas_start = 1'b0;
    // writes to settings only store; state is untouched
    if (wr && avs_address == tas_pkg::REG_TRIG_CFG) begin
      tcfg_d.source = avs_writedata[1:0];
      tcfg_d.infinite = avs_writedata[2];
    end
    if (wr && avs_address == tas_pkg::REG_TRIG_COUNT)
      tcount_d = avs_writedata;
    if (wr && avs_address == tas_pkg::REG_ARM2_CFG)
      arm2_ext_d = avs_writedata[0];
    // raise timer to the legal minimum, ms units; no upper clamp
    if (wr && avs_address == tas_pkg::REG_TIMER_MS) begin
      if (avs_writedata < tas_pkg::TIMER_MIN_MS)
        timer_ms_d = tas_pkg::TIMER_MIN_MS;
      else
        timer_ms_d = avs_writedata;
    end
    // interval counter runs in the trigger and measure states, cleared elsewhere
    if (st_q == tas_pkg::TAS_TRIG || st_q == tas_pkg::TAS_MEAS) begin
      if (tick) begin
        if (ms_cnt_q + 32'h0000_0001 >= timer_ms_q) begin
          ms_cnt_d = 32'h0000_0000;
          tmr_fire_d = 1'b1;
        end else begin
          ms_cnt_d = ms_cnt_q + 32'h0000_0001;
        end
      end
    end else begin
      ms_cnt_d = 32'h0000_0000;
    end
    case (st_q)
      tas_pkg::TAS_IDLE: begin
        // no source acts here; only initiate leaves
        done_cnt_d = 32'h0000_0000;
        if (wr && avs_address == tas_pkg::REG_CMD
            && avs_writedata[tas_pkg::CMD_INIT])
          st_d = arm2_ext_q ? tas_pkg::TAS_ARM2 : tas_pkg::TAS_TRIG;
      end
      tas_pkg::TAS_ARM2: begin
        if (ext_rise) st_d = tas_pkg::TAS_TRIG;
      end
      tas_pkg::TAS_TRIG: begin
        // timer reads on entry: entry behaves like a fired interval
        if (!tcfg_q.infinite && tcount_q != 32'h0000_0000
            && done_cnt_q >= tcount_q) begin
          st_d = tas_pkg::TAS_IDLE;
        end else begin
          case (tcfg_q.source)
            tas_pkg::SRC_IMM: meas_start = 1'b1;
            tas_pkg::SRC_EXT: meas_start = ext_rise;
            tas_pkg::SRC_TIM:
              meas_start = (done_cnt_q == 32'h0000_0000) | tmr_fire_q;
            default: meas_start = 1'b0;
          endcase
          if (meas_start) st_d = tas_pkg::TAS_MEAS;
        end
      end
      tas_pkg::TAS_MEAS: begin
        if (meas_done) begin
          st_d = tas_pkg::TAS_TRIG;
          // infinite count never counts toward an exit
          if (!tcfg_q.infinite) done_cnt_d = done_cnt_q + 32'h0000_0001;
          else done_cnt_d = 32'h0000_0001;
        end
      end
      default: st_d = tas_pkg::TAS_IDLE;
    endcase
    // abort and reset command override everything
    if (wr && avs_address == tas_pkg::REG_CMD) begin
      if (avs_writedata[tas_pkg::CMD_ABORT]) st_d = tas_pkg::TAS_IDLE;
      if (avs_writedata[tas_pkg::CMD_RESET]) begin
        st_d = tas_pkg::TAS_IDLE;
        tcfg_d.source = tas_pkg::SRC_IMM;
        tcfg_d.infinite = 1'b0;
        tcount_d = 32'h0000_0001;
        arm2_ext_d = 1'b0;
        timer_ms_d = tas_pkg::TIMER_RST_MS;
      end
    end
  end

  // range settings kept per function
  always_comb begin
    fsel_d = fsel_q;
    auto_d = auto_q;
    for (int f = 0; f < tas_pkg::NUM_FUNC; f++) rng_d[f] = rng_q[f];
    if (wr && avs_address == tas_pkg::REG_RANGE_SEL)
      fsel_d = avs_writedata[1:0];
    if (wr && avs_address == tas_pkg::REG_RANGE_REQ)
      rng_d[fsel_q] = pick;
    if (wr && avs_address == tas_pkg::REG_AUTORANGE)
      auto_d[fsel_q] = avs_writedata[0];
  end

  // status system, buffer fill and service request
  always_comb begin
    mev_d = mev_q;
    men_d = men_q;
    sre_d = sre_q;
    srq_d = srq_q;
    fired_d = fired_q;
    feed_d = feed_q;
    pts_d = pts_q;
    stored_d = stored_q;
    msb_prev_d = msb_now;
    // a read of the event register clears it after returning it
    if (rd && avs_address == tas_pkg::REG_MEAS_EVENT) begin
      mev_d = 16'h0000;
      fired_d = 1'b0;
    end
    if (wr && avs_address == tas_pkg::REG_CMD
        && avs_writedata[tas_pkg::CMD_CLS]) begin
      mev_d = 16'h0000;
      fired_d = 1'b0;
    end
    if (wr && avs_address == tas_pkg::REG_BUF_CFG) begin
      feed_d = avs_writedata[1:0];
      pts_d = avs_writedata[31:16];
      stored_d = 16'h0000;
    end
    // buffer storing; events set after clears so a set wins
    if (st_q == tas_pkg::TAS_MEAS && meas_done) begin
      mev_d[tas_pkg::MEV_RDG_AVAIL] = 1'b1;
      if (feed_q == tas_pkg::FEED_ALWAYS
          || (feed_q == tas_pkg::FEED_NEXT && stored_q < pts_q)) begin
        stored_d = stored_q + 16'h0001;
        if (feed_q == tas_pkg::FEED_NEXT && stored_q + 16'h0001 >= pts_q)
          mev_d[tas_pkg::MEV_BUF_FULL] = 1'b1;
      end
    end
    if (wr && avs_address == tas_pkg::REG_MEAS_ENABLE)
      men_d = avs_writedata[15:0];
    if (wr && avs_address == tas_pkg::REG_SRQ_ENABLE)
      sre_d = avs_writedata[7:0];
    // status setup is restored only on preset, never on reset command
    if (wr && avs_address == tas_pkg::REG_CMD
        && avs_writedata[tas_pkg::CMD_PRESET]) begin
      men_d = tas_pkg::STATUS_EN_RST;
      sre_d = tas_pkg::SRQ_EN_RST;
    end
    // a poll releases the line; a request in the same cycle still wins
    if (serial_poll) srq_d = 1'b0;
    // either edge of the enabled summary requests service, once
    if ((msb_now != msb_prev_q) && sre_q[tas_pkg::STB_MSB]
        && !fired_q) begin
      srq_d = 1'b1;
      if (msb_now) fired_d = 1'b1;
    end
  end

  // read mux, registered for the answer edge
  always_comb begin
    rdata_d = rdata_q;
    if (rd) begin
      case (avs_address)
        tas_pkg::REG_TRIG_CFG:
          rdata_d = {29'h0, tcfg_q.infinite, tcfg_q.source};
        tas_pkg::REG_TRIG_COUNT: rdata_d = tcount_q;
        tas_pkg::REG_TIMER_MS: rdata_d = timer_ms_q;
        tas_pkg::REG_ARM2_CFG: rdata_d = {31'h0, arm2_ext_q};
        tas_pkg::REG_RANGE_SEL: rdata_d = {30'h0, fsel_q};
        tas_pkg::REG_RANGE_FS: rdata_d = fs_sel;
        tas_pkg::REG_AUTORANGE: rdata_d = {31'h0, auto_q[fsel_q]};
        tas_pkg::REG_MEAS_EVENT: rdata_d = {16'h0, mev_q};
        tas_pkg::REG_MEAS_ENABLE: rdata_d = {16'h0, men_q};
        tas_pkg::REG_SRQ_ENABLE: rdata_d = {24'h0, sre_q};
        tas_pkg::REG_STATUS_BYTE: rdata_d = {24'h0, poll_status};
        tas_pkg::REG_BUF_CFG: rdata_d = {pts_q, 14'h0, feed_q};
        tas_pkg::REG_TRIG_STATE: rdata_d = {30'h0, st_q};
        tas_pkg::REG_READ_CNT: rdata_d = {16'h0, stored_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // status byte: summary plus request bit (64) for the poll
  assign poll_status = {1'b0, srq_q, 5'h00, msb_now};
  assign srq_out = srq_q;

  // all state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
      st_q <= tas_pkg::TAS_IDLE;
      tcfg_q <= '{source: tas_pkg::SRC_IMM, infinite: 1'b0};
      arm2_ext_q <= 1'b0;
      tcount_q <= 32'h0000_0001;
      done_cnt_q <= 32'h0000_0000;
      timer_ms_q <= tas_pkg::TIMER_RST_MS;
      ms_cnt_q <= 32'h0000_0000;
      tmr_fire_q <= 1'b0;
      fsel_q <= 2'h0;
      auto_q <= '0;
      for (int f = 0; f < tas_pkg::NUM_FUNC; f++) rng_q[f] <= 3'd4;
      mev_q <= 16'h0000;
      men_q <= tas_pkg::STATUS_EN_RST;
      sre_q <= tas_pkg::SRQ_EN_RST;
      msb_prev_q <= 1'b0;
      srq_q <= 1'b0;
      fired_q <= 1'b0;
      feed_q <= tas_pkg::FEED_NEVER;
      pts_q <= tas_pkg::BUF_PTS_RST;
      stored_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      st_q <= st_d;
      tcfg_q <= tcfg_d;
      arm2_ext_q <= arm2_ext_d;
      tcount_q <= tcount_d;
      done_cnt_q <= done_cnt_d;
      timer_ms_q <= timer_ms_d;
      ms_cnt_q <= ms_cnt_d;
      tmr_fire_q <= tmr_fire_d;
      fsel_q <= fsel_d;
      auto_q <= auto_d;
      rng_q <= rng_d;
      mev_q <= mev_d;
      men_q <= men_d;
      sre_q <= sre_d;
      msb_prev_q <= msb_prev_d;
      srq_q <= srq_d;
      fired_q <= fired_d;
      feed_q <= feed_d;
      pts_q <= pts_d;
      stored_q <= stored_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end
endmodule // tas_top

// *** verif/tas_top_sva.sv ***
// assertion checker for the trigger model and service request ports
`timescale 1ns/10ps
module tas_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ext_trig_in,
  input wire logic serial_poll,
  input wire logic meas_done,
  input wire logic meas_start,
  input wire logic srq_out,
  input wire logic [7:0] poll_status
);
  logic cmd_wr, busy_q, busy_d, idle_q, idle_d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a command lands only at the edge where waitrequest is low
  assign cmd_wr = avs_write && !avs_waitrequest &&
                  avs_address == tas_pkg::REG_CMD;
  // track a reading in flight and whether only idle is legal
  always_comb begin
    busy_d = busy_q;
    idle_d = idle_q;
    if (meas_start)
      busy_d = 1'b1;
    else if (meas_done || cmd_wr)
      busy_d = 1'b0;
    if (cmd_wr && avs_writedata[tas_pkg::CMD_INIT])
      idle_d = 1'b0;
    else if (cmd_wr && avs_writedata[tas_pkg::CMD_ABORT])
      idle_d = 1'b1;
    else if (cmd_wr && avs_writedata[tas_pkg::CMD_RESET])
      idle_d = 1'b1;
  end
  // helper state, idle after reset so a stray start is caught at once
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      busy_q <= busy_d;
      idle_q <= idle_d;
    end
  end
  property p_wait_start;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_start: assert property (p_wait_start)
    else $error("no wait cycle at start of access");
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access held more than one wait cycle");
  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest high with no access");
  property p_rd_hold;
    !avs_read && !$past(avs_read) |-> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_poll_drop;
    serial_poll && $stable(poll_status[0]) |=> !srq_out;
  endproperty
  a_poll_drop: assert property (p_poll_drop)
    else $error("service request held after serial poll");
  property p_rst_quiet;
    $fell(rst) |-> !srq_out && !meas_start && avs_readdata == '0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  property p_start_pulse;
    meas_start |=> !meas_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start wider than one cycle");
  property p_start_single;
    meas_start |-> !busy_q;
  endproperty
  a_start_single: assert property (p_start_single)
    else $error("start while a reading is in flight");
  property p_idle_quiet;
    meas_start |-> !idle_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("reading started while idle");
  c_srq: cover property ($rose(srq_out));
  c_poll: cover property (serial_poll && srq_out);
  c_abort: cover property (cmd_wr && avs_writedata[tas_pkg::CMD_ABORT]);
endmodule // tas_top_sva
bind tas_top tas_top_sva i_tas_top_sva (.clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .ext_trig_in, .serial_poll, .meas_done,
  .meas_start, .srq_out, .poll_status);

// *** verif/tas_meas_model.sv ***
// measurement engine stand-in: answers each start with one done pulse
`timescale 1ns/10ps
module tas_meas_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic meas_start,
  input wire logic [7:0] lat,
  output logic meas_done
);
  logic run_q;
  logic [7:0] cnt_q;
  // latency set by the bench, so prompt and slow readings both occur
  always_ff @(posedge clk) begin
    meas_done <= 1'b0;
    if (rst) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (meas_start) begin
      run_q <= 1'b1;
      cnt_q <= lat;
    end else if (run_q && cnt_q == 8'h00) begin
      run_q <= 1'b0;
      meas_done <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // tas_meas_model

// *** verif/tas_top_bench.sv ***
// self-checking bench for trigger model, ranges and service request
`timescale 1ns/10ps
module tas_top_bench;
  logic clk, rst, avs_read, avs_write, ext_trig_in, serial_poll;
  logic avs_waitrequest, meas_start, meas_done, srq_out;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [7:0] poll_status, lat;
  logic [31:0] rq [5] = '{32'h0000_0166, 32'h0000_1473, 32'h0000_1480,
                           32'h0003_E800, 32'h0003_E880};
  logic [31:0] fs [5] = '{32'h0000_0002, 32'h0000_0014, 32'h0000_00C8,
                           32'h0000_03E8, 32'h0000_2710};
  int n_errors = 0;
  int samples_checked = 0;
  int n_starts = 0;
  tas_top i_tas_top (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_trig_in,
    .serial_poll, .meas_done, .meas_start, .srq_out, .poll_status);
  tas_meas_model i_tas_meas_model (.clk, .rst, .meas_start, .lat,
    .meas_done);
  // clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count readings the block starts
  always @(posedge clk) begin
    if (meas_start === 1'b1)
      n_starts <= n_starts + 1;
  end
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // one avalon access, held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 40);
    if (t >= 40)
      n_errors++;
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    cmp($sformatf("reg%0d", a), e, rdv);
  endtask
  task automatic ext_pulse();
    @(posedge clk);
    ext_trig_in <= 1'b1;
    repeat (4) @(posedge clk);
    ext_trig_in <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // bounded wait for a total of starts, then a quiet spell
  task automatic starts(input int n, input int lim);
    int t;
    t = 0;
    while (n_starts < n && t < lim) begin
      @(posedge clk);
      t++;
    end
    repeat (40) @(posedge clk);
    cmp("starts", 32'(n), 32'(n_starts));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    ext_trig_in = 1'b0;
    serial_poll = 1'b0;
    lat = 8'h01;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0000);
    rd(tas_pkg::REG_TRIG_CFG, 32'h0000_0000);
    rd(tas_pkg::REG_TIMER_MS, 32'h0000_0001);
    rd(tas_pkg::REG_RANGE_FS, 32'h0000_2710);
    rd(6'h3F, 32'h0000_0000);
    $display("test defaults done");
    for (int i = 0; i < 5; i++) begin
      wr(tas_pkg::REG_RANGE_REQ, rq[i]);
      rd(tas_pkg::REG_RANGE_FS, fs[i]);
    end
    wr(tas_pkg::REG_RANGE_SEL, 32'h0000_0001);
    wr(tas_pkg::REG_RANGE_REQ, 32'h0000_1400);
    wr(tas_pkg::REG_AUTORANGE, 32'h0000_0001);
    wr(tas_pkg::REG_RANGE_SEL, 32'h0000_0000);
    rd(tas_pkg::REG_AUTORANGE, 32'h0000_0000);
    rd(tas_pkg::REG_RANGE_FS, 32'h0000_2710);
    wr(tas_pkg::REG_RANGE_SEL, 32'h0000_0001);
    rd(tas_pkg::REG_RANGE_FS, 32'h0000_0014);
    $display("test ranges done");
    wr(tas_pkg::REG_TRIG_CFG, 32'h0000_0005);
    rd(tas_pkg::REG_TRIG_CFG, 32'h0000_0005);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0000);
    ext_pulse();
    starts(0, 1);
    wr(tas_pkg::REG_CMD, 32'h0000_0001);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0003);
    repeat (3) ext_pulse();
    starts(3, 100);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0003);
    wr(tas_pkg::REG_CMD, 32'h0000_0002);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0000);
    ext_pulse();
    starts(3, 1);
    $display("test external trigger done");
    lat = 8'h0A;
    wr(tas_pkg::REG_TRIG_CFG, 32'h0000_0000);
    wr(tas_pkg::REG_TRIG_COUNT, 32'h0000_0003);
    wr(tas_pkg::REG_ARM2_CFG, 32'h0000_0001);
    wr(tas_pkg::REG_CMD, 32'h0000_0001);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0001);
    starts(3, 1);
    ext_pulse();
    starts(6, 200);
    rd(tas_pkg::REG_TRIG_STATE, 32'h0000_0000);
    wr(tas_pkg::REG_TRIG_CFG, 32'h0000_0001);
    wr(tas_pkg::REG_CMD, 32'h0000_0004);
    rd(tas_pkg::REG_TRIG_CFG, 32'h0000_0000);
    rd(tas_pkg::REG_ARM2_CFG, 32'h0000_0000);
    rd(tas_pkg::REG_TRIG_COUNT, 32'h0000_0001);
    $display("test arm layer and reset done");
    lat = 8'h01;
    wr(tas_pkg::REG_TIMER_MS, 32'h0000_0000);
    rd(tas_pkg::REG_TIMER_MS, 32'h0000_0001);
    wr(tas_pkg::REG_TIMER_MS, 32'h0000_0002);
    wr(tas_pkg::REG_TRIG_CFG, 32'h0000_0006);
    wr(tas_pkg::REG_CMD, 32'h0000_0001);
    starts(7, 10);
    wr(tas_pkg::REG_CMD, 32'h0000_0002);
    $display("test timer done");
    wr(tas_pkg::REG_CMD, 32'h0000_0018);
    wr(tas_pkg::REG_MEAS_ENABLE, 32'h0000_0200);
    wr(tas_pkg::REG_SRQ_ENABLE, 32'h0000_0001);
    wr(tas_pkg::REG_BUF_CFG, 32'h0004_0001);
    wr(tas_pkg::REG_TRIG_COUNT, 32'h0000_0006);
    wr(tas_pkg::REG_TRIG_CFG, 32'h0000_0000);
    wr(tas_pkg::REG_CMD, 32'h0000_0001);
    starts(13, 300);
    cmp("srq", 32'h0000_0001, 32'(srq_out));
    cmp("rqs", 32'h0000_0001, 32'(poll_status[tas_pkg::STB_RQS]));
    rd(tas_pkg::REG_READ_CNT, 32'h0000_0004);
    @(posedge clk);
    serial_poll <= 1'b1;
    @(posedge clk);
    serial_poll <= 1'b0;
    repeat (20) @(posedge clk);
    cmp("srq", 32'h0000_0000, 32'(srq_out));
    // summary toggles again, but the latched register stays quiet
    wr(tas_pkg::REG_MEAS_ENABLE, 32'h0000_0000);
    wr(tas_pkg::REG_MEAS_ENABLE, 32'h0000_0200);
    repeat (4) @(posedge clk);
    cmp("srq", 32'h0000_0000, 32'(srq_out));
    bus(1'b0, tas_pkg::REG_MEAS_EVENT, 32'h0000_0000);
    cmp("full", 32'h0000_0001, 32'(rdv[tas_pkg::MEV_BUF_FULL]));
    bus(1'b0, tas_pkg::REG_MEAS_EVENT, 32'h0000_0000);
    cmp("full", 32'h0000_0000, 32'(rdv[tas_pkg::MEV_BUF_FULL]));
    wr(tas_pkg::REG_CMD, 32'h0000_0004);
    rd(tas_pkg::REG_MEAS_ENABLE, 32'h0000_0200);
    rd(tas_pkg::REG_SRQ_ENABLE, 32'h0000_0001);
    wr(tas_pkg::REG_CMD, 32'h0000_0010);
    rd(tas_pkg::REG_MEAS_ENABLE, 32'h0000_0000);
    $display("test service request done");
    test_done();
  end
endmodule // tas_top_bench
